// ===== hdl/eeprom_host.sv
// Notes on behaviour
// - chip-select bits carry address bits 15 to 17
// - single-select variant sends select bits 0,1 zero
// - control byte is code, selects, low write bit
// - up to 63 more bytes, committed at stop
// - page writes kept inside one aligned page
// - poll repeats start and control until acknowledged
// - read control byte has read bit one
// - last read byte unacknowledged, then stop
// - random read: address, repeated start, read
// - each acknowledge fetches the next byte
module eeprom_host
  import eeprom_host_pkg::*;
#(
  parameter logic [3:0] DEV_CODE = 4'h5, // arbitrary value, set per system
  parameter bit SINGLE_SEL = 1'b0,
  parameter int QTR = QTR_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmd_valid,
  input wire cmd_t cmd,
  output logic cmd_ready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wdata_valid,
  output logic wdata_ready,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic nack_err,
  input wire logic wp_req,
  output logic write_protect,
  output logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  state_t state;
  step_t step;
  logic [1:0] phase;
  logic [3:0] bit_idx;
  logic [7:0] shreg;
  logic [6:0] cnt;
  logic [14:0] ptr;
  logic [2:0] sel;
  logic rd;
  logic poll;
  logic got_ack;
  logic sda_meta;
  logic sda_s;
  logic [15:0] div;
  logic tick;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire take = cmd_valid && cmd_ready && (cmd.len != 7'h00);
  wire [6:0] page_room = PAGE_BYTES - {1'b0, cmd.addr[5:0]};
  wire [6:0] wr_len = (cmd.len > page_room) ? page_room : cmd.len;
  // writes always carry their own address; only reads may reuse the mirror
  wire [14:0] rd_base = (cmd.use_addr || !cmd.rd) ? cmd.addr[14:0] : ptr;
  wire [15:0] rd_room = ADDR_END - {1'b0, rd_base};
  wire [6:0] rd_len = ({9'h000, cmd.len} > rd_room) ? rd_room[6:0] : cmd.len;
  wire [2:0] sel_in = {cmd.addr[17], SINGLE_SEL ? 2'b00 : cmd.addr[16:15]};
  wire [7:0] ctrl_byte = {DEV_CODE, sel, step == STEP_CTRLR};
  wire is_ack_bit = bit_idx == LAST_BIT;
  wire last_rd = cnt == 7'h01;
  wire drive_low = is_ack_bit ? (step == STEP_RDATA && !last_rd)
                              : (step != STEP_RDATA && !shreg[7]);
  wire byte_end = tick && state == ST_BYTE && phase == 2'h3 && is_ack_bit;
  wire fifo_ready = state == ST_FETCH;
  wire fifo_valid;
  wire [DATA_W-1:0] fifo_data;

  // ----------------------------------------
  // write data buffer
  // ----------------------------------------
  byte_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_data(wdata),
    .in_valid(wdata_valid),
    .in_ready(wdata_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready)
  );

  // ----------------------------------------
  // quarter-bit divider and data line sync
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div <= '0;
      tick <= 1'b0;
      sda_meta <= 1'b1;
      sda_s <= 1'b1;
      sda_out <= 1'b0;
    end else begin
      tick <= div == 16'(QTR - 1);
      div <= (div == 16'(QTR - 1)) ? '0 : div + 16'h0001;
      sda_meta <= sda_in;
      sda_s <= sda_meta;
      sda_out <= 1'b0;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      step <= STEP_CTRLW;
      phase <= '0;
      bit_idx <= '0;
      shreg <= 8'hff;
      cnt <= '0;
      ptr <= '0;
      sel <= '0;
      rd <= 1'b0;
      poll <= 1'b0;
      got_ack <= 1'b0;
      cmd_ready <= 1'b1;
      rd_data <= '0;
      rd_valid <= 1'b0;
      done <= 1'b0;
      nack_err <= 1'b0;
      write_protect <= 1'b0;
      scl <= 1'b1;
      sda_oe <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      done <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          // protect level only moves between commands, never across a stop
          write_protect <= wp_req;
          if (take) begin
            cmd_ready <= 1'b0;
            nack_err <= 1'b0;
            rd <= cmd.rd;
            sel <= sel_in;
            ptr <= rd_base;
            cnt <= cmd.rd ? rd_len : wr_len;
            step <= (cmd.rd && !cmd.use_addr) ? STEP_CTRLR : STEP_CTRLW;
            phase <= '0;
            state <= ST_START;
          end
        end
        ST_START: if (tick) begin
          phase <= phase + 2'h1;
          unique case (phase)
            2'h0: begin
              scl <= 1'b0;
              sda_oe <= 1'b0;
            end
            2'h1: scl <= 1'b1;
            2'h2: sda_oe <= 1'b1;
            2'h3: begin
              scl <= 1'b0;
              shreg <= ctrl_byte;
              bit_idx <= '0;
              state <= ST_BYTE;
            end
          endcase
        end
        ST_FETCH: if (fifo_valid) begin
          shreg <= fifo_data;
          bit_idx <= '0;
          phase <= '0;
          state <= ST_BYTE;
        end
        ST_BYTE: if (tick) begin
          phase <= phase + 2'h1;
          unique case (phase)
            2'h0: sda_oe <= drive_low;
            2'h1: scl <= 1'b1;
            2'h2: begin
              if (is_ack_bit) got_ack <= !sda_s;
              else shreg <= {shreg[6:0], sda_s};
            end
            2'h3: begin
              scl <= 1'b0;
              bit_idx <= is_ack_bit ? 4'h0 : bit_idx + 4'h1;
            end
          endcase
          if (byte_end) begin
            if (step == STEP_RDATA) begin
              rd_data <= shreg;
              rd_valid <= 1'b1;
              ptr <= ptr + 15'h0001;
              cnt <= cnt - 7'h01;
              shreg <= 8'hff;
              if (last_rd) state <= ST_STOP;
            end else if (!got_ack) begin
              if (step == STEP_POLL) begin
                state <= ST_START;
              end else begin
                nack_err <= 1'b1;
                poll <= 1'b0;
                state <= ST_STOP;
              end
            end else begin
              unique case (step)
                STEP_CTRLW: begin
                  step <= STEP_ADDRH;
                  shreg <= {1'b0, ptr[14:8]};
                end
                STEP_ADDRH: begin
                  step <= STEP_ADDRL;
                  shreg <= ptr[7:0];
                end
                STEP_ADDRL: begin
                  // reads send no data after the address: repeated start reuses the pointer; writes fetch data
                  step <= rd ? STEP_CTRLR : STEP_WDATA;
                  state <= rd ? ST_START : ST_FETCH;
                end
                STEP_WDATA: begin
                  ptr <= {ptr[14:6], ptr[5:0] + 6'h01};
                  cnt <= cnt - 7'h01;
                  poll <= last_rd;
                  state <= last_rd ? ST_STOP : ST_FETCH;
                end
                STEP_CTRLR: begin
                  step <= STEP_RDATA;
                  shreg <= 8'hff;
                end
                STEP_POLL: begin
                  poll <= 1'b0;
                  state <= ST_STOP;
                end
                default: state <= ST_STOP;
              endcase
            end
          end
        end
        ST_STOP: if (tick) begin
          phase <= phase + 2'h1;
          unique case (phase)
            2'h0: begin
              scl <= 1'b0;
              sda_oe <= 1'b1;
            end
            2'h1: scl <= 1'b1;
            2'h2: sda_oe <= 1'b0;
            2'h3: begin
              if (poll) begin
                step <= STEP_POLL;
                state <= ST_START;
              end else begin
                cmd_ready <= 1'b1;
                done <= 1'b1;
                state <= ST_IDLE;
              end
            end
          endcase
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_ctrl_code: assert property (@(posedge clk) disable iff (!rstn)
    ($past(state) == ST_START && state == ST_BYTE) |->
      shreg[7:4] == DEV_CODE && shreg[0] == (step == STEP_CTRLR))
    else $error("control byte code or direction wrong");
  chk_chip_ext: assert property (@(posedge clk) disable iff (!rstn)
    ($past(state) == ST_START && state == ST_BYTE) |-> shreg[3:1] == sel)
    else $error("select bits do not carry the upper address");
  chk_sel_variant: assert property (@(posedge clk) disable iff (!rstn)
    (SINGLE_SEL && state == ST_BYTE && $past(state) == ST_START) |-> shreg[2:1] == 2'b00)
    else $error("select bits 0 and 1 not zero");
  chk_page_room: assert property (@(posedge clk) disable iff (!rstn)
    ($past(state) == ST_IDLE && state == ST_START && !rd) |->
      cnt != 7'h00 && ({1'b0, cnt} + {2'b00, ptr[5:0]}) <= 8'h40)
    else $error("page write crosses the page end");
  chk_read_bound: assert property (@(posedge clk) disable iff (!rstn)
    ($past(state) == ST_IDLE && state == ST_START && rd) |->
      ({9'h000, cnt} + {1'b0, ptr}) <= ADDR_END)
    else $error("sequential read runs past the device end");
  chk_poll_retry: assert property (@(posedge clk) disable iff (!rstn)
    (byte_end && step == STEP_POLL && !got_ack) |=> state == ST_START && step == STEP_POLL)
    else $error("poll not repeated after refusal");
  chk_random_restart: assert property (@(posedge clk) disable iff (!rstn)
    (byte_end && step == STEP_ADDRL && rd && got_ack) |=>
      state == ST_START && step == STEP_CTRLR ##1 sda_oe == 1'b0)
    else $error("random read lacks repeated start");
  chk_last_nack: assert property (@(posedge clk) disable iff (!rstn)
    (state == ST_BYTE && step == STEP_RDATA && is_ack_bit && phase == 2'h2) |->
      sda_oe == !last_rd)
    else $error("read acknowledge level wrong");
  chk_stop_after_nack: assert property (@(posedge clk) disable iff (!rstn)
    (byte_end && step == STEP_RDATA && last_rd) |=> state == ST_STOP ##1 rd_valid == 1'b0)
    else $error("no stop after last read byte");
  chk_sda_stable: assert property (@(posedge clk) disable iff (!rstn)
    (state == ST_BYTE && $changed(sda_oe)) |-> !scl && !$past(scl))
    else $error("data line moved while clock high");

endmodule : eeprom_host

// ===== hdl/eeprom_host_pkg.sv
package eeprom_host_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int SCL_HZ = 100_000;
  // one quarter of a serial clock period, in core cycles
  localparam int QTR_CYC = CLK_HZ / (4 * SCL_HZ);

  // ----------------------------------------
  // memory geometry
  // ----------------------------------------
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic [6:0] PAGE_BYTES = 7'h40;
  localparam logic [15:0] ADDR_END = 16'h8000;
  localparam logic [2:0] ACK_BIT = 3'h0;
  localparam logic [3:0] LAST_BIT = 4'h8;

  // ----------------------------------------
  // command carrier
  // ----------------------------------------
  typedef struct packed {
    logic rd;
    logic use_addr;
    logic [17:0] addr;
    logic [6:0] len;
  } cmd_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_START = 5'h02,
    ST_FETCH = 5'h04,
    ST_BYTE  = 5'h08,
    ST_STOP  = 5'h10
  } state_t;

  typedef enum logic [6:0] {
    STEP_CTRLW = 7'h01,
    STEP_ADDRH = 7'h02,
    STEP_ADDRL = 7'h04,
    STEP_WDATA = 7'h08,
    STEP_CTRLR = 7'h10,
    STEP_RDATA = 7'h20,
    STEP_POLL  = 7'h40
  } step_t;

endpackage : eeprom_host_pkg

// ===== hdl/byte_fifo.sv
module byte_fifo
  import eeprom_host_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;

  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [PW:0] next_count = count + (PW + 1)'(push) - (PW + 1)'(pop);
  wire [PW-1:0] next_wr = (wr_ptr == LAST_IDX) ? '0 : wr_ptr + 1'b1;
  wire [PW-1:0] next_rd = (rd_ptr == LAST_IDX) ? '0 : rd_ptr + 1'b1;

  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // flags registered from the next count so both are honest one cycle ahead
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) wr_ptr <= next_wr;
      if (pop) rd_ptr <= next_rd;
      count <= next_count;
      in_ready <= next_count != FULL_CNT;
      out_valid <= next_count != '0;
    end
  end

endmodule : byte_fifo

// ===== verif/eeprom_model.sv
module eeprom_model #(
  parameter logic [3:0] CODE = 4'h5, // arbitrary value
  parameter logic [2:0] SEL = 3'h3,
  parameter int BUSY_NS = 60000
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic wp,
  output logic pull
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [32768];
  logic [7:0] pbuf [64];
  logic [63:0] mark;
  logic [14:0] ptr;
  logic [7:0] sh;
  logic busy, dack, wrote;
  int bits, ph;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    ptr = '0;
    busy = 0;
    pull = 0;
    ph = 0;
    bits = 0;
    dack = 0;
    wrote = 0;
    mark = '0;
  end
  // ----
  // start and stop
  // ----
  always @(negedge sda) if (scl === 1'b1) begin
    ph = 1;
    bits = 0;
    wrote = 0;
    mark = '0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    if (wrote && !wp) begin
      // untouched bytes of the page keep their old value
      foreach (pbuf[i]) if (mark[i]) mem[{ptr[14:6], 6'(i)}] = pbuf[i];
      busy = 1;
      busy <= #BUSY_NS 1'b0;
    end
    ph = 0;
    wrote = 0;
  end
  // ----
  // bit level
  // ----
  always @(posedge scl) if (ph != 0) begin
    if (bits < 8) begin
      sh = {sh[6:0], sda};
      bits++;
    end else begin
      bits = 0;
      if (ph == 5 && !dack) begin
        ptr = ptr + 15'h1;
        if (sda) ph = 0;
      end
      dack = 0;
    end
  end
  always @(negedge scl) begin
    pull = 0;
    if (ph == 5 && bits < 8) pull = !mem[ptr][7 - bits];
    else if (bits == 8 && ph != 5 && ph != 0) begin
      dack = 1;
      case (ph)
        1: if (sh[7:4] == CODE && sh[3:1] == SEL && !busy) ph = sh[0] ? 5 : 2;
        else begin
          ph = 0;
          dack = 0;
        end
        2: begin
          ptr[14:8] = sh[6:0];
          ph = 3;
        end
        3: begin
          ptr[7:0] = sh;
          ph = 4;
        end
        default: begin
          pbuf[ptr[5:0]] = sh;
          mark[ptr[5:0]] = 1'b1;
          ptr[5:0] = ptr[5:0] + 6'h1;
          wrote = 1;
        end
      endcase
      pull = dack;
    end
  end
endmodule : eeprom_model

// ===== verif/eeprom_host_tb.sv
module eeprom_host_tb
  import eeprom_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BUSY_NS = 60000;
  localparam int BUSY_CYC = BUSY_NS / 50;
  logic clk = 0, rstn = 0, cmd_valid = 0, wdata_valid = 0, wp_req = 0, stall = 0;
  logic sda_in, pull, cmd_ready, wdata_ready, rd_valid, done, nack_err;
  logic write_protect, scl, sda_out, sda_oe;
  cmd_t cmd = '0;
  logic [7:0] wdata = '0;
  logic [7:0] rd_data, b;
  logic [7:0] ref_mem [32768];
  logic [7:0] exp_q [$];
  logic [7:0] wq [$];
  int error_cnt = 0, checks = 0, elapsed;
  logic [17:0] base;
  // pull-up: released line reads high
  assign sda_in = (sda_oe ? sda_out : 1'b1) & !pull;
  always #25 clk = !clk;
  eeprom_host #(.SINGLE_SEL(1'b1), .QTR(4)) DUT (.clk(clk), .rstn(rstn),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .wdata(wdata),
    .wdata_valid(wdata_valid), .wdata_ready(wdata_ready), .rd_data(rd_data),
    .rd_valid(rd_valid), .done(done), .nack_err(nack_err), .wp_req(wp_req),
    .write_protect(write_protect), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe));
  // single-select host: only the top select bit reaches the device
  eeprom_model #(.SEL(3'h4), .BUSY_NS(BUSY_NS)) partner (.scl(scl),
    .sda(sda_in), .wp(write_protect), .pull(pull));
  // ----
  // helpers
  // ----
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic run_cmd(logic rd, logic ua, logic [17:0] a, logic [6:0] n, logic en);
    int k;
    @(posedge clk);
    #2 cmd = '{rd, ua, a, n};
    cmd_valid = 1;
    k = 0;
    do begin @(negedge clk); k++; end while (cmd_ready !== 1'b1 && k < 50);
    @(posedge clk);
    #2 cmd_valid = 0;
    elapsed = 0;
    do begin @(negedge clk); elapsed++; end while (done !== 1'b1 && elapsed < 60000);
    if (k >= 50 || elapsed >= 60000) begin
      error_cnt++;
      tally_and_finish();
    end
    check("nack_err", 16'(nack_err), 16'(en));
    check("leftover", 16'(exp_q.size()), 16'h0);
  endtask : run_cmd
  task automatic load_exp(logic [14:0] a, int n);
    for (int i = 0; i < n; i++) exp_q.push_back(ref_mem[15'(a + i)]);
  endtask : load_exp
  // write bytes go in through the fifo; the stall flag holds them back
  always @(posedge clk) begin
    if (wdata_valid && wdata_ready === 1'b1) void'(wq.pop_front());
    #2;
    wdata_valid = wq.size() != 0 && !stall;
    if (wq.size() != 0) wdata = wq[0];
  end
  always @(negedge clk) if (rd_valid === 1'b1) begin
    if (exp_q.size() == 0) check("rd_extra", 16'h1, 16'h0);
    else check("rd_data", 16'(rd_data), 16'(exp_q.pop_front()));
  end
  // ----
  // sequence
  // ----
  initial begin
    foreach (ref_mem[i]) ref_mem[i] = 8'hff;
    elapsed = $urandom(62);
    repeat (12) @(posedge clk);
    #2 check("reset", {12'h0, cmd_ready, scl, sda_oe, write_protect}, 16'hc);
    rstn = 1;
    // select bits 0 and 1 set on purpose: the single-select host must clear them
    base = {3'h7, 9'($urandom()), 6'h28};
    for (int i = 0; i < 20; i++) begin
      b = 8'($urandom());
      wq.push_back(b);
      ref_mem[15'(base[14:0] + i)] = b;
    end
    repeat (30) @(posedge clk);
    #2 check("fifo_full", 16'(wdata_ready), 16'h0);
    stall = 1;
    fork
      run_cmd(0, 0, base, 20, 0);
      begin repeat (3000) @(posedge clk); #2 stall = 0; end
    join
    $display("test page_write done");
    load_exp(base[14:0] - 15'h4, 24);
    run_cmd(1, 1, base - 18'h4, 24, 0);
    load_exp(base[14:0] + 15'h14, 3);
    run_cmd(1, 0, base, 3, 0);
    $display("test reads done");
    b = 8'($urandom());
    wq.push_back(b);
    ref_mem[15'h7fff] = b;
    run_cmd(0, 0, {3'h7, 15'h7fff}, 1, 0);
    check("poll_wait", 16'(elapsed > BUSY_CYC + 576), 16'h1);
    load_exp(15'h7fff, 1);
    run_cmd(1, 1, {3'h7, 15'h7fff}, 1, 0);
    load_exp(15'h0, 1);
    run_cmd(1, 0, {3'h7, 15'h0}, 1, 0);
    $display("test byte_write done");
    repeat (3) @(posedge clk);
    #2 wp_req = 1;
    wq.push_back(8'h5a);
    wq.push_back(8'ha5);
    fork
      run_cmd(0, 0, base, 2, 0);
      begin repeat (100) @(posedge clk); #2 wp_req = 0; end
    join
    check("wp_fast", 16'(elapsed < BUSY_CYC), 16'h1);
    load_exp(base[14:0], 2);
    run_cmd(1, 1, base, 2, 0);
    $display("test protect done");
    // top select bit low: no device on the bus answers
    run_cmd(1, 1, {3'h3, 15'h0}, 1, 1);
    @(posedge clk);
    #2 cmd = '{1'b0, 1'b0, base, 7'h0};
    cmd_valid = 1;
    repeat (5) @(posedge clk);
    #2 check("len_zero", {14'h0, cmd_ready, done}, 16'h2);
    cmd_valid = 0;
    $display("test select_and_len done");
    tally_and_finish();
  end
endmodule : eeprom_host_tb
